/* File: hdl/aisr_top.sv */
// Register side of the converter input select, amplifier setup and result capture.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "aisr_cfg.svh"
module aisr_top (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire aisr_pkg::aisr_word_t WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic WB_ERR_O,
	input wire aisr_pkg::aisr_word_t CONV_RESULT,
	input wire logic CONV_RESULT_VLD,
	input wire aisr_pkg::aisr_half_t CONV_SAMPLE,
	input wire logic CONV_SAMPLE_VLD,
	output aisr_pkg::aisr_sel_t POS_SEL,
	output aisr_pkg::aisr_sel_t NEG_SEL,
	output logic POS_SEL_LEGAL,
	output logic NEG_SEL_LEGAL,
	output logic [1:0] ROUTE_SEL,
	output logic ROUTE_LEGAL,
	output logic [4:0] AMP_GAIN_X,
	output logic [6:0] AMP_BIAS_PCT,
	output logic [4:0] AMP_SAMP_CLKS,
	output logic AMP_POWER,
	output logic CONV_START
);
	import aisr_pkg::*;

	logic [7:0] amp_r;
	aisr_sel_t pos_r;
	aisr_sel_t neg_r;
	logic [1:0] route_r;
	logic [2:0] start_r;
	logic low_latency_keepalive_r;
	aisr_word_t res_r;
	aisr_half_t smp_r;
	logic ack_r;
	logic err_r;
	logic [31:0] dat_r;
	logic start_out_r;
	aisr_sel_t pos_out_r;
	aisr_sel_t neg_out_r;
	logic pos_ok_r;
	logic neg_ok_r;
	logic [1:0] route_out_r;
	logic route_ok_r;
	logic [4:0] gain_out_r;
	logic [6:0] bias_out_r;
	logic [4:0] sdur_out_r;
	logic power_r;

	// Bus decode.
	wire [5:0] idx = WB_ADR_I[7:2];
	wire req = WB_CYC_I & WB_STB_I & ~ack_r & ~err_r;
	wire hit_converter_control_a = idx == `AISR_IDX_CONVERTER_CONTROL_A;
	wire hit_cmd = idx == `AISR_IDX_CMD;
	wire hit_amp = idx == `AISR_IDX_AMP;
	wire hit_pos = idx == `AISR_IDX_POS;
	wire hit_neg = idx == `AISR_IDX_NEG;
	wire hit_res = idx[5:2] == 4'(`AISR_IDX_RES0 >> 2);
	wire hit_smp = idx[5:1] == 5'(`AISR_IDX_SMPL >> 1);
	wire hit = hit_converter_control_a | hit_cmd | hit_amp | hit_pos | hit_neg | hit_res | hit_smp;
	wire wr_lane = req & WB_WE_I & WB_SEL_I[0] & hit;
	wire wr_converter_control_a = wr_lane & hit_converter_control_a;
	wire wr_cmd = wr_lane & hit_cmd;
	wire wr_amp = wr_lane & hit_amp;
	wire wr_pos = wr_lane & hit_pos;
	wire wr_neg = wr_lane & hit_neg;
	wire [7:0] wbyte = WB_DAT_I[7:0];

	wire [7:0] res_byte = res_r[{idx[1:0], 3'h0} +: 8];
	wire [7:0] smp_byte = idx[0] ? smp_r[15:8] : smp_r[7:0];
	wire [7:0] sel_byte_pos = {route_r, pos_r};
	wire [7:0] sel_byte_neg = {route_r, neg_r};
	wire [7:0] converter_control_a_byte = 8'(low_latency_keepalive_r) << `AISR_BIT_LOW_LATENCY_KEEPALIVE;
	wire [7:0] rd_byte = hit_converter_control_a ? converter_control_a_byte :
		hit_cmd ? {5'h00, start_r} :
		hit_amp ? amp_r :
		hit_pos ? sel_byte_pos :
		hit_neg ? sel_byte_neg :
		hit_res ? res_byte :
		hit_smp ? smp_byte : 8'h00;

	// Field decode.
	wire [2:0] gain_f = amp_r[`AISR_GAIN_HI:`AISR_GAIN_LO];
	wire [1:0] bias_f = amp_r[`AISR_BIAS_HI:`AISR_BIAS_LO];
	wire [1:0] sdur_f = amp_r[`AISR_SDUR_HI:`AISR_SDUR_LO];
	wire amp_en = amp_r[`AISR_BIT_AMPEN];
	wire [4:0] gain_nxt = (gain_f <= 3'h4) ? 5'(5'h01 << gain_f) : 5'h00;
	wire [6:0] bias_nxt = (bias_f == 2'h0) ? `AISR_BIAS_PCT0 :
		(bias_f == 2'h1) ? `AISR_BIAS_PCT1 :
		(bias_f == 2'h2) ? `AISR_BIAS_PCT2 : `AISR_BIAS_PCT3;
	wire [4:0] sdur_nxt = (sdur_f == 2'h0) ? `AISR_SDUR_CLK0 :
		(sdur_f == 2'h1) ? `AISR_SDUR_CLK1 :
		(sdur_f == 2'h2) ? `AISR_SDUR_CLK2 : 5'h00;
	wire route_ok_nxt = (route_r == AISR_ROUTE_DIRECT) | (route_r == AISR_ROUTE_AMP);
	wire power_nxt = amp_en & ((route_r == AISR_ROUTE_AMP) | low_latency_keepalive_r);
	wire pos_ok_nxt = (pos_r <= 6'h0F) | ((pos_r >= 6'h30) & (pos_r <= 6'h33));
	wire neg_ok_nxt = (neg_r <= 6'h07) | (neg_r == 6'h30) | (neg_r == 6'h31) | (neg_r == 6'h33);
	wire start_nxt = (wr_pos & (start_r == `AISR_START_ON_POS)) |
		(wr_neg & (start_r == `AISR_START_ON_NEG));

	// Bus answer: one wait state, unmapped addresses end in an error.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & hit;
			err_r <= req & ~hit;
			dat_r <= (req & hit & ~WB_WE_I) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Reserved codes are kept as written so software reads back what it wrote.
	// Stored as written.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			amp_r <= `AISR_RST_AMP;
			pos_r <= `AISR_RST_SEL;
			neg_r <= `AISR_RST_SEL;
			start_r <= `AISR_RST_START;
			low_latency_keepalive_r <= 1'b0;
		end else begin
			if (wr_amp) begin
				amp_r <= wbyte;
			end
			if (wr_pos) begin
				pos_r <= wbyte[5:0];
			end
			if (wr_neg) begin
				neg_r <= wbyte[5:0];
			end
			if (wr_cmd) begin
				start_r <= wbyte[`AISR_START_HI:`AISR_START_LO];
			end
			if (wr_converter_control_a) begin
				low_latency_keepalive_r <= wbyte[`AISR_BIT_LOW_LATENCY_KEEPALIVE];
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			route_r <= `AISR_RST_ROUTE;
		end else if (wr_pos | wr_neg) begin
			route_r <= wbyte[`AISR_ROUTE_HI:`AISR_ROUTE_LO];
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			res_r <= `AISR_RST_RES;
			smp_r <= `AISR_RST_SMP;
		end else begin
			if (CONV_RESULT_VLD) begin
				res_r <= CONV_RESULT;
			end
			if (CONV_SAMPLE_VLD) begin
				smp_r <= CONV_SAMPLE;
			end
		end
	end

	// Outputs are registered so the analog side never sees decode glitches.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			start_out_r <= 1'b0;
			pos_out_r <= `AISR_RST_SEL;
			neg_out_r <= `AISR_RST_SEL;
			pos_ok_r <= 1'b1;
			neg_ok_r <= 1'b1;
			route_out_r <= `AISR_RST_ROUTE;
			route_ok_r <= 1'b1;
			gain_out_r <= 5'h01;
			bias_out_r <= `AISR_BIAS_PCT0;
			sdur_out_r <= `AISR_SDUR_CLK2;
			power_r <= 1'b0;
		end else begin
			start_out_r <= start_nxt;
			pos_out_r <= pos_r;
			neg_out_r <= neg_r;
			pos_ok_r <= pos_ok_nxt;
			neg_ok_r <= neg_ok_nxt;
			route_out_r <= route_r;
			route_ok_r <= route_ok_nxt;
			gain_out_r <= gain_nxt;
			bias_out_r <= bias_nxt;
			sdur_out_r <= sdur_nxt;
			power_r <= power_nxt;
		end
	end

	assign WB_ACK_O = ack_r;
	assign WB_ERR_O = err_r;
	assign WB_DAT_O = dat_r;
	assign CONV_START = start_out_r;
	assign POS_SEL = pos_out_r;
	assign NEG_SEL = neg_out_r;
	assign POS_SEL_LEGAL = pos_ok_r;
	assign NEG_SEL_LEGAL = neg_ok_r;
	assign ROUTE_SEL = route_out_r;
	assign ROUTE_LEGAL = route_ok_r;
	assign AMP_GAIN_X = gain_out_r;
	assign AMP_BIAS_PCT = bias_out_r;
	assign AMP_SAMP_CLKS = sdur_out_r;
	assign AMP_POWER = power_r;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	property p_gain;
		wr_amp && WB_DAT_I[7:5] == 3'h3 |-> ##2 AMP_GAIN_X == 5'h08;
	endproperty
	a_gain: assert property (p_gain) else $error("gain code 3 not 8x");

	property p_gain_rsv;
		wr_amp && WB_DAT_I[7:5] > 3'h4 |-> ##2 AMP_GAIN_X == 5'h00;
	endproperty
	a_gain_rsv: assert property (p_gain_rsv) else $error("reserved gain not zero");

	property p_bias;
		wr_amp && WB_DAT_I[4:3] == 2'h2 |-> ##2 AMP_BIAS_PCT == 7'h32;
	endproperty
	a_bias: assert property (p_bias) else $error("bias code 2 not 50 percent");

	property p_sdur;
		wr_amp && WB_DAT_I[2:1] == 2'h0 |-> ##2 AMP_SAMP_CLKS == 5'h06;
	endproperty
	a_sdur: assert property (p_sdur) else $error("sampling code 0 not 6 clocks");

	property p_power_off;
		##1 AMP_POWER |-> $past(amp_en) && ($past(route_r) == 2'h1 || $past(low_latency_keepalive_r));
	endproperty
	a_power_off: assert property (p_power_off) else $error("amplifier powered wrongly");

	property p_keepalive;
		amp_en && low_latency_keepalive_r && route_r == 2'h0 |=> AMP_POWER;
	endproperty
	a_keepalive: assert property (p_keepalive) else $error("keepalive lost power");

	property p_route;
		wr_pos |=> sel_byte_neg[7:6] == $past(WB_DAT_I[7:6]) && ROUTE_SEL == $past(route_r);
	endproperty
	a_route: assert property (p_route) else $error("route not shared");

	property p_route_legal;
		route_r == 2'h2 |=> !ROUTE_LEGAL;
	endproperty
	a_route_legal: assert property (p_route_legal) else $error("route 2 legal");

	property p_pos;
		pos_r == 6'h32 |=> POS_SEL_LEGAL && POS_SEL == 6'h32;
	endproperty
	a_pos: assert property (p_pos) else $error("temperature code not legal");

	property p_neg;
		neg_r == 6'h32 || neg_r == 6'h08 |=> !NEG_SEL_LEGAL;
	endproperty
	a_neg: assert property (p_neg) else $error("reserved negative legal");

	property p_res_ro;
		!CONV_RESULT_VLD |=> res_r == $past(res_r);
	endproperty
	a_res_ro: assert property (p_res_ro) else $error("result changed without capture");

	property p_res_byte;
		req && !WB_WE_I && idx == 6'h12 |=> WB_DAT_O == {24'h00_0000, $past(res_r[23:16])};
	endproperty
	a_res_byte: assert property (p_res_byte) else $error("result byte 2 misplaced");

	property p_smp_byte;
		req && !WB_WE_I && idx == 6'h15 |=> WB_DAT_O == {24'h00_0000, $past(smp_r[15:8])};
	endproperty
	a_smp_byte: assert property (p_smp_byte) else $error("sample high byte misplaced");

	property p_smp;
		CONV_SAMPLE_VLD |=> smp_r == $past(CONV_SAMPLE);
	endproperty
	a_smp: assert property (p_smp) else $error("sample not captured");

	property p_start;
		wr_neg && start_r == 3'h3 |=> CONV_START ##1 !CONV_START;
	endproperty
	a_start: assert property (p_start) else $error("negative write did not start");

	property p_start_cause;
		CONV_START |-> $past(wr_pos) || $past(wr_neg);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("start without write");

	property p_rsv_kept;
		wr_pos && WB_DAT_I[5:0] == 6'h20 |=> pos_r == 6'h20;
	endproperty
	a_rsv_kept: assert property (p_rsv_kept) else $error("reserved code not stored");

	property p_route_neg;
		wr_neg |=> sel_byte_pos[7:6] == $past(WB_DAT_I[7:6]);
	endproperty
	a_route_neg: assert property (p_route_neg) else $error("route not shared from negative");

	property p_smp_low;
		req && !WB_WE_I && idx == 6'h14 |=> WB_DAT_O == {24'h00_0000, $past(smp_r[7:0])};
	endproperty
	a_smp_low: assert property (p_smp_low) else $error("sample low byte misplaced");

	c_err: cover property (req && !hit ##1 WB_ERR_O);
	c_start_pos: cover property (wr_pos && start_r == 3'h2 ##1 CONV_START);
	c_keepalive: cover property (AMP_POWER && ROUTE_SEL == 2'h0);
	c_capture: cover property (CONV_RESULT_VLD && CONV_SAMPLE_VLD);
endmodule // aisr_top

/* File: hdl/aisr_cfg.svh */
// Offsets, field positions, reset values and decode figures of the input select block.
`ifndef AISR_CFG_SVH
`define AISR_CFG_SVH
`define AISR_IDX_CONVERTER_CONTROL_A 6'h00
`define AISR_IDX_CMD 6'h0A
`define AISR_IDX_AMP 6'h0B
`define AISR_IDX_POS 6'h0C
`define AISR_IDX_NEG 6'h0D
`define AISR_IDX_RES0 6'h10
`define AISR_IDX_RES1 6'h11
`define AISR_IDX_RES2 6'h12
`define AISR_IDX_RES3 6'h13
`define AISR_IDX_SMPL 6'h14
`define AISR_IDX_SMPH 6'h15
`define AISR_BIT_LOW_LATENCY_KEEPALIVE 5
`define AISR_GAIN_HI 7
`define AISR_GAIN_LO 5
`define AISR_BIAS_HI 4
`define AISR_BIAS_LO 3
`define AISR_SDUR_HI 2
`define AISR_SDUR_LO 1
`define AISR_BIT_AMPEN 0
`define AISR_ROUTE_HI 7
`define AISR_ROUTE_LO 6
`define AISR_START_HI 2
`define AISR_START_LO 0
`define AISR_RST_AMP 8'h04
`define AISR_RST_SEL 6'h00
`define AISR_RST_ROUTE 2'h0
`define AISR_RST_START 3'h0
`define AISR_RST_RES 32'h0000_0000
`define AISR_RST_SMP 16'h0000
`define AISR_START_ON_POS 3'h2
`define AISR_START_ON_NEG 3'h3
`define AISR_SDUR_CLK0 5'h06
`define AISR_SDUR_CLK1 5'h0F
`define AISR_SDUR_CLK2 5'h14
`define AISR_BIAS_PCT0 7'h64
`define AISR_BIAS_PCT1 7'h4B
`define AISR_BIAS_PCT2 7'h32
`define AISR_BIAS_PCT3 7'h19
`endif

/* File: hdl/aisr_pkg.sv */
// Types shared by the input select and result block.
package aisr_pkg;
	typedef enum logic [1:0] {
		AISR_ROUTE_DIRECT = 2'h0,
		AISR_ROUTE_AMP = 2'h1
	} aisr_route_t;
	typedef logic [5:0] aisr_sel_t;
	typedef logic [31:0] aisr_word_t;
	typedef logic [15:0] aisr_half_t;
endpackage

/* File: tb/aisr_conv_model.sv */
// Behavioural converter core that answers start pulses with two accumulated samples.
`timescale 1ns/1ps
module aisr_conv_model #(
	parameter int LAT = 3
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CONV_START,
	output aisr_pkg::aisr_word_t CONV_RESULT,
	output logic CONV_RESULT_VLD,
	output aisr_pkg::aisr_half_t CONV_SAMPLE,
	output logic CONV_SAMPLE_VLD
);
	import aisr_pkg::*;
	int cnt_r;
	logic [1:0] left_r;
	logic [15:0] seq_r;
	logic [31:0] acc_r;
	// Outside a valid cycle the data toggles, so a stray capture is seen.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cnt_r <= 0;
			left_r <= 2'h0;
			seq_r <= 16'h0000;
			acc_r <= 32'h0000_0000;
			CONV_RESULT <= 32'h0000_0000;
			CONV_SAMPLE <= 16'h0000;
			CONV_RESULT_VLD <= 1'b0;
			CONV_SAMPLE_VLD <= 1'b0;
		end else begin
			CONV_RESULT_VLD <= 1'b0;
			CONV_SAMPLE_VLD <= 1'b0;
			CONV_RESULT <= ~CONV_RESULT;
			CONV_SAMPLE <= ~CONV_SAMPLE;
			if (CONV_START) begin
				left_r <= 2'h2;
				cnt_r <= LAT;
				acc_r <= 32'h0000_0000;
			end else if (left_r != 2'h0) begin
				if (cnt_r != 0) begin
					cnt_r <= cnt_r - 1;
				end else begin
					seq_r <= seq_r + 16'h0001;
					CONV_SAMPLE <= 16'hA001 + seq_r;
					CONV_SAMPLE_VLD <= 1'b1;
					acc_r <= acc_r + {16'h0000, 16'hA001 + seq_r};
					left_r <= left_r - 2'h1;
					cnt_r <= LAT;
					if (left_r == 2'h1) begin
						CONV_RESULT <= acc_r + {16'h0000, 16'hA001 + seq_r};
						CONV_RESULT_VLD <= 1'b1;
					end
				end
			end
		end
	end
endmodule // aisr_conv_model

/* File: tb/aisr_top_tb_top.sv */
// Register-level testbench of the input select and result block.
`timescale 1ns/1ps
`include "aisr_cfg.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module aisr_top_tb_top;
	import aisr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, st;
	logic [7:0] adr = 8'h00;
	aisr_word_t wdat = 32'h0, rdat, res;
	aisr_half_t smp;
	logic rv, sv, pl, nl, rl, pw;
	aisr_sel_t ps, ns;
	logic [1:0] rs;
	logic [4:0] gx, sc;
	logic [6:0] bp;
	int miscompares = 0, cmp_count = 0, starts = 0, cyc_n = 0;
	logic [7:0] q;
	logic e;
	aisr_top DUT (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.WB_ERR_O(err), .CONV_RESULT(res), .CONV_RESULT_VLD(rv), .CONV_SAMPLE(smp),
		.CONV_SAMPLE_VLD(sv), .POS_SEL(ps), .NEG_SEL(ns), .POS_SEL_LEGAL(pl),
		.NEG_SEL_LEGAL(nl), .ROUTE_SEL(rs), .ROUTE_LEGAL(rl), .AMP_GAIN_X(gx),
		.AMP_BIAS_PCT(bp), .AMP_SAMP_CLKS(sc), .AMP_POWER(pw), .CONV_START(st));
	aisr_conv_model #(.LAT(3)) PART (.CLK_SYS(clk), .RST(rst), .CONV_START(st),
		.CONV_RESULT(res), .CONV_RESULT_VLD(rv), .CONV_SAMPLE(smp), .CONV_SAMPLE_VLD(sv));
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (st === 1'b1) starts++;
		cyc_n++;
		if (cyc_n == 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Holds the request until the acknowledge or error edge; a lost answer ends at the cycle ceiling.
	task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		@(posedge clk);
		while (ack !== 1'b1 && err !== 1'b1) begin
			@(posedge clk);
		end
		q = rdat[7:0];
		e = err;
		`CHK("read upper bits", 24'h0, rdat[31:8])
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] ex);
		wb(1'b0, idx, 8'h00);
		`CHK("read error", 1'b0, e)
		`CHK("read data", ex, q)
	endtask
	task automatic settle();
		@(posedge clk);
		@(posedge clk);
	endtask
	task automatic conv(input int s);
		logic [31:0] t;
		int n;
		n = 0;
		t = 32'h0001_4003 + 4 * s;
		while (rv !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < 4; i++) rd(6'(`AISR_IDX_RES0 + i), t[8*i+:8]);
		rd(`AISR_IDX_SMPL, 8'(8'h02 + 2 * s));
		rd(`AISR_IDX_SMPH, 8'hA0);
	endtask
	logic [4:0] gtab[8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00, 5'h00};
	logic [6:0] btab[4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
	logic [4:0] stab[4] = '{5'h06, 5'h0F, 5'h14, 5'h00};
	logic [5:0] pc[10] = '{6'h00, 6'h0F, 6'h10, 6'h2F, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h3F};
	logic pok[10] = '{1, 1, 0, 0, 1, 1, 1, 1, 0, 0};
	logic [5:0] nc[8] = '{6'h00, 6'h07, 6'h08, 6'h30, 6'h31, 6'h32, 6'h33, 6'h3F};
	logic nok[8] = '{1, 1, 0, 1, 1, 0, 1, 0};
	logic [3:0] ptab[5] = '{4'b0100, 4'b0111, 4'b0010, 4'b1101, 4'b1000};
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		settle();
		`CHK("gain", 5'h01, gx)
		`CHK("reset sampling", 5'h14, sc)
		`CHK("power", 1'b0, pw)
		rd(`AISR_IDX_AMP, `AISR_RST_AMP);
		rd(`AISR_IDX_POS, 8'h00);
		rd(`AISR_IDX_NEG, 8'h00);
		for (int i = 0; i < 4; i++) rd(6'(`AISR_IDX_RES0 + i), 8'h00);
		rd(`AISR_IDX_SMPH, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, `AISR_IDX_AMP, {i[2:0], i[1:0], i[1:0], 1'b0});
			rd(`AISR_IDX_AMP, {i[2:0], i[1:0], i[1:0], 1'b0});
			`CHK("gain", gtab[i], gx)
			`CHK("bias", btab[i%4], bp)
			`CHK("sampling", stab[i%4], sc)
		end
		$display("test amplifier fields done");
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, `AISR_IDX_CONVERTER_CONTROL_A, {2'h0, ptab[i][3], 5'h00});
			wb(1'b1, `AISR_IDX_AMP, {7'h02, ptab[i][2]});
			wb(1'b1, `AISR_IDX_POS, {1'b0, ptab[i][1], 6'h01});
			settle();
			`CHK("power", ptab[i][0], pw)
		end
		$display("test power done");
		for (int i = 0; i < 10; i++) begin
			wb(1'b1, `AISR_IDX_POS, {2'h1, pc[i]});
			rd(`AISR_IDX_NEG, 8'h40);
			`CHK("pos code", pc[i], ps)
			`CHK("pos legal", pok[i], pl)
			`CHK("route", 2'h1, rs)
			`CHK("route legal", 1'b1, rl)
		end
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, `AISR_IDX_NEG, {2'h2, nc[i]});
			rd(`AISR_IDX_POS, 8'hBF);
			`CHK("neg code", nc[i], ns)
			`CHK("neg legal", nok[i], nl)
			`CHK("route legal", 1'b0, rl)
		end
		`CHK("no start", 0, starts)
		$display("test selectors done");
		wb(1'b1, `AISR_IDX_CMD, {5'h00, `AISR_START_ON_POS});
		wb(1'b1, `AISR_IDX_POS, 8'h01);
		conv(0);
		`CHK("starts", 1, starts)
		wb(1'b1, `AISR_IDX_NEG, 8'h01);
		settle();
		`CHK("starts", 1, starts)
		wb(1'b1, `AISR_IDX_CMD, {5'h00, `AISR_START_ON_NEG});
		wb(1'b1, `AISR_IDX_NEG, 8'h02);
		conv(1);
		wb(1'b1, `AISR_IDX_POS, 8'h02);
		settle();
		`CHK("starts", 2, starts)
		$display("test start done");
		wb(1'b1, `AISR_IDX_RES0, 8'hFF);
		wb(1'b1, `AISR_IDX_SMPL, 8'hFF);
		rd(`AISR_IDX_RES0, 8'h07);
		rd(`AISR_IDX_SMPL, 8'h04);
		wb(1'b1, 6'h3F, 8'h55);
		`CHK("unmapped error", 1'b1, e)
		$display("test read only done");
		wb(1'b1, `AISR_IDX_AMP, 8'h60);
		wb(1'b1, `AISR_IDX_POS, 8'h42);
		settle();
		`CHK("gain before reset", 5'h08, gx)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle();
		`CHK("reset pos code", 6'h00, ps)
		`CHK("reset route", 2'h0, rs)
		`CHK("reset gain", 5'h01, gx)
		`CHK("reset sampling", 5'h14, sc)
		rd(`AISR_IDX_AMP, `AISR_RST_AMP);
		rd(`AISR_IDX_RES0, 8'h00);
		rd(`AISR_IDX_SMPL, 8'h00);
		$display("test second reset done");
		end_of_test();
	end
endmodule // aisr_top_tb_top
